// >>> dv/mrsrx_clock_ctrl_tb.sv
// Self-checking bench for the receive clock control block.
`timescale 1ns/1ps
module mrsrx_clock_ctrl_tb;
    import mrsrx_pkg::*;
    localparam int DW = 16;
    localparam int HD = 8;
    logic clock = 1'h0;
    logic sys_rst = 1'h1;
    logic trsSeen = 1'h0;
    logic lineEnd = 1'h0;
    logic edhErrorFlag = 1'h0;
    logic [CRC_WIDTH-1:0] expectedCrc = '0;
    logic [WORD_WIDTH-1:0] wordSeed = '0;
    logic [WORD_WIDTH-1:0] rxWordIn, rxParallelWord;
    logic [SD_WIDTH-1:0] sdWordIn;
    logic wordRateStrobe, highDefModeFlag, hdFrequencyChoice;
    logic wordValid, locked, crcErrorLed, edhErrorLed;
    int fail_count = 0;
    int checked = 0;
    int n;

    //////////////////////////////////////////////////////////////////////
    // Design, far side and clock.
    mrsrx_clock_ctrl #(.DWELL(DW), .HOLD(HD)) u_dut (.clock(clock), .sys_rst(sys_rst),
        .rxWordIn(rxWordIn), .sdWordIn(sdWordIn), .wordRateStrobe(wordRateStrobe),
        .trsSeen(trsSeen), .lineEnd(lineEnd), .expectedCrc(expectedCrc),
        .edhErrorFlag(edhErrorFlag), .highDefModeFlag(highDefModeFlag),
        .hdFrequencyChoice(hdFrequencyChoice), .rxParallelWord(rxParallelWord),
        .wordValid(wordValid), .locked(locked), .crcErrorLed(crcErrorLed),
        .edhErrorLed(edhErrorLed));
    mrsrx_partner u_far (.clock(clock), .highDefModeFlag(highDefModeFlag),
        .wordSeed(wordSeed), .rxWordIn(rxWordIn), .sdWordIn(sdWordIn),
        .wordRateStrobe(wordRateStrobe));
    always #25 clock = ~clock;

    //////////////////////////////////////////////////////////////////////
    // Helpers.
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #5;
    endtask

    task automatic check(input logic [WORD_WIDTH-1:0] got, input logic [WORD_WIDTH-1:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        sys_rst = 1'h1;
        tick(20);
        sys_rst = 1'h0;
    endtask

    // Waits for the mode flag to reach a level, counting cycles.
    task automatic wait_mode(input logic lvl);
        n = 0;
        while (highDefModeFlag !== lvl && n < 4 * DW) begin
            tick(1);
            n++;
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////
    // Watchdog cuts a hang short.
    initial begin
        #2000000;
        fail_count++;
        stop_test();
    end

    // Test sequence.
    initial begin
        #5;
        do_reset();
        check(highDefModeFlag, 1'h1);
        check(hdFrequencyChoice, 1'h0);
        check({locked, crcErrorLed, edhErrorLed}, 3'h0);
        $display("test reset done");
        // Hunt walks nominal HD, then the 1.001 rate, then SD, then back.
        n = 0;
        while (hdFrequencyChoice !== 1'h1 && n < 4 * DW) begin
            tick(1);
            n++;
        end
        check(n >= DW - 2 && n <= DW + 2, 1'h1);
        check(highDefModeFlag, 1'h1);
        wait_mode(1'h0);
        check(n >= DW - 2 && n <= DW + 2, 1'h1);
        wait_mode(1'h1);
        check(hdFrequencyChoice, 1'h0);
        $display("test hunt done");
        // HD lock and word pass-through.
        do_reset();
        wordSeed = 20'h5a3c1;
        tick(3);
        trsSeen = 1'h1;
        tick(1);
        trsSeen = 1'h0;
        tick(3);
        check(locked, 1'h1);
        check(rxParallelWord, 20'h5a3c1);
        check(wordValid, 1'h1);
        tick(3 * DW);
        check({highDefModeFlag, hdFrequencyChoice}, 2'h2);
        $display("test hd lock done");
        // EDH indicator stretch.
        edhErrorFlag = 1'h1;
        tick(1);
        edhErrorFlag = 1'h0;
        tick(2);
        check(edhErrorLed, 1'h1);
        tick(HD + 4);
        check(edhErrorLed, 1'h0);
        // Zero lines give a zero checksum; a wrong carried value lights the LED.
        wordSeed = '0;
        for (int i = 0; i < 3; i++) begin
            tick(6);
            expectedCrc = (i == 2) ? 18'h00001 : 18'h00000;
            lineEnd = 1'h1;
            tick(1);
            lineEnd = 1'h0;
            // The verdict stands until the next line end, then the LED stretches HOLD cycles.
            if (i < 2)
                tick(HD + 4);
            tick(2);
            if (i > 0)
                check(crcErrorLed, i == 2);
        end
        $display("test error indicators done");
        // With no framing for MISS_LIMIT word ticks the lock is dropped.
        tick(MISS_LIMIT);
        check(locked, 1'h0);
        $display("test lock loss done");
        // SD lock: word in the top half, held between strobes.
        do_reset();
        wordSeed = 20'h002b7;
        wait_mode(1'h0);
        trsSeen = 1'h1;
        tick(8);
        trsSeen = 1'h0;
        tick(2);
        check(locked, 1'h1);
        check(highDefModeFlag, 1'h0);
        for (int i = 0; i < 8; i++) begin
            check(rxParallelWord, {10'h2b7, 10'h000});
            tick(1);
        end
        $display("test sd lock done");
        stop_test();
    end
endmodule

// >>> dv/mrsrx_partner.sv
// Behavioural stand-in for the transceiver and the bit recovery unit.
`timescale 1ns/1ps
module mrsrx_partner
    import mrsrx_pkg::*;
(
    // Recovered clock and mode.
    input  wire logic                  clock,
    input  wire logic                  highDefModeFlag,
    // Word pattern chosen by the bench.
    input  wire logic [WORD_WIDTH-1:0] wordSeed,
    // Words towards the receiver.
    output logic [WORD_WIDTH-1:0]      rxWordIn,
    output logic [SD_WIDTH-1:0]        sdWordIn,
    output logic                       wordRateStrobe
);
    logic [1:0] divCount;

    //////////////////////////////////////////////////////////////////////
    // Everything moves on the one recovered clock, just after its edge.
    initial begin
        divCount = 2'h0;
        rxWordIn = '0;
        sdWordIn = '0;
        wordRateStrobe = 1'h0;
    end

    // HD words every edge; SD words valid only with the strobe, garbage between.
    always @(posedge clock) begin
        #5;
        divCount = divCount + 2'h1;
        wordRateStrobe = !highDefModeFlag && divCount == 2'h0;
        rxWordIn = highDefModeFlag ? wordSeed : ~rxWordIn;
        sdWordIn = wordRateStrobe ? wordSeed[SD_WIDTH-1:0] : ~wordSeed[SD_WIDTH-1:0];
    end
endmodule

// >>> include/mrsrx_pkg.sv
// Package of constants shared by the multi-rate receive clocking block.
// Notes on behaviour
// RQ1: Outside synthesizer supplies both HD references: nominal rate and rate over 1.001.
// RQ2: Four reference inputs in two pairs; exactly one is the active reference.
// RQ3: Pair-member select picks one of each pair; attribute picks standard or low-jitter.
// RQ4: Pair attribute is fixed at configuration; only two inputs switch at run time.
// RQ5: Three references need outside multiplexing or reconfiguring the pair attribute.
// RQ6: Switching by reconfiguration takes hundreds of microseconds, far slower than a mux.
// RQ7: Unused transmit user clocks are tied to the receive word and fabric clocks.
// RQ8: Receiver outputs, parallel word included, update only on the word clock rising edge.
// RQ9: Word clock runs at HD word rate in HD mode, reference rate in SD mode.
// RQ10: Received parallel word is 20 bits: luma and chroma for HIGH_DEF_MODE_FLAG recovery width.
// RQ11: Fabric clock equals word clock in frequency and phase, one shared net.
// RQ12: Both receive user clocks come from the recovered clock, never the reference.
// RQ13: In SD the recovered clock drives user clocks and the bit recovery input.
// RQ14: Receiver drives a rate choice telling the synthesizer which HD frequency to make.
// RQ15: Receiver accepts both HD rates and 270 Mb/s SD, switching its clocking.
// RQ16: Received video is checked for CRC and EDH errors shown on indicator outputs.
// RQ17: Clock-enable style recovery uses one global clock per channel.
// RQ18: Receiver drives a high-def mode flag onto the pair-member select input.
// RQ19: In SD the recovery strobe fires once per divider period so logic runs at 27 MHz.
// RQ20: Mode flag and rate choice change only synchronously to the receiver clock.
package mrsrx_pkg;
    localparam int          WORD_WIDTH      = 20;
    localparam int          SD_WIDTH        = 10;
    localparam int          CLOCK_MHZ       = 20;
    localparam int          DWELL_US        = 100;
    localparam int          DWELL_CYCLES    = DWELL_US * CLOCK_MHZ;
    localparam int          MISS_LIMIT      = 2048;
    localparam int          HOLD_CYCLES     = 4096;
    localparam logic        HD_RESET        = 1'h1;
    localparam logic        RATE_RESET      = 1'h0;
    localparam logic [9:0]  TRS_ONES        = 10'h3ff;
    localparam logic [9:0]  TRS_ZEROS       = 10'h000;
    localparam int          CRC_WIDTH       = 18;
    typedef enum logic [1:0] {
        HUNT_HD_NOM  = 2'b00,
        HUNT_HD_MIL  = 2'b01,
        HUNT_SD      = 2'b10,
        LOCKED       = 2'b11
    } mrsrx_state_type;
endpackage

// >>> rtl/mrsrx_clock_ctrl.sv
// Rate hunting, reference selection and error indication for the multi-rate receiver.
`timescale 1ns/1ps
module mrsrx_clock_ctrl
    import mrsrx_pkg::*;
#(
    parameter int DWELL = DWELL_CYCLES,
    parameter int HOLD  = HOLD_CYCLES
)(
    // Word clock taken from the recovered clock, and reset.
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    // Data from transceiver and bit recovery.
    input  wire logic [WORD_WIDTH-1:0] rxWordIn,
    input  wire logic [SD_WIDTH-1:0]   sdWordIn,
    input  wire logic                  wordRateStrobe,
    // Framing hints from the deframer.
    input  wire logic                  trsSeen,
    input  wire logic                  lineEnd,
    input  wire logic [CRC_WIDTH-1:0]  expectedCrc,
    input  wire logic                  edhErrorFlag,
    // Reference selection outputs.
    output logic                       highDefModeFlag,
    output logic                       hdFrequencyChoice,
    // Received word and indicators.
    output logic [WORD_WIDTH-1:0]      rxParallelWord,
    output logic                       wordValid,
    output logic                       locked,
    output logic                       crcErrorLed,
    output logic                       edhErrorLed
);
    mrsrx_state_type state_q;
    logic [15:0]     dwell_q;
    logic [11:0]     miss_q;
    logic [12:0]     hold_q;
    logic            crcRaw;
    logic            wordTick;

    // In SD only the strobe advances logic; in HD every word clock edge does.
    assign wordTick = highDefModeFlag | wordRateStrobe; // [RQ19] [RQ17]

    ////////////////////////////////////////////////////////////////////////////
    // Rate hunt: try nominal HD, 1.001 HD, then SD until framing is found.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= HUNT_HD_NOM;
            dwell_q <= '0;
        end else begin
            unique case (state_q)
                HUNT_HD_NOM, HUNT_HD_MIL, HUNT_SD: begin
                    if (wordTick && trsSeen) begin
                        state_q <= LOCKED;
                        dwell_q <= '0;
                    end else if (dwell_q == 16'(DWELL - 1)) begin
                        dwell_q <= '0;
                        unique case (state_q)
                            HUNT_HD_NOM: state_q <= HUNT_HD_MIL;
                            HUNT_HD_MIL: state_q <= HUNT_SD;
                            default:     state_q <= HUNT_HD_NOM;
                        endcase // [RQ15]
                    end else begin
                        dwell_q <= dwell_q + 16'h0001;
                    end
                end
                LOCKED: begin
                    if (miss_q == 12'(MISS_LIMIT - 1)) begin
                        state_q <= HUNT_HD_NOM;
                    end
                end
            endcase
        end
    end

    // Count word ticks without framing while locked.
    always_ff @(posedge clock) begin
        if (sys_rst || state_q != LOCKED) begin
            miss_q <= '0;
        end else if (wordTick && trsSeen) begin
            miss_q <= '0;
        end else if (wordTick) begin
            miss_q <= miss_q + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered reference selection: changes only on this clock.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            highDefModeFlag   <= HD_RESET;
            hdFrequencyChoice <= RATE_RESET;
        end else begin
            unique case (state_q)
                HUNT_HD_NOM: begin
                    highDefModeFlag   <= 1'b1; // [RQ18] [RQ20]
                    hdFrequencyChoice <= 1'b0; // [RQ14]
                end
                HUNT_HD_MIL: begin
                    highDefModeFlag   <= 1'b1; // [RQ18]
                    hdFrequencyChoice <= 1'b1; // [RQ14] [RQ20]
                end
                HUNT_SD: begin
                    highDefModeFlag   <= 1'b0; // [RQ18] [RQ2] [RQ3]
                    hdFrequencyChoice <= hdFrequencyChoice;
                end
                LOCKED: begin
                    highDefModeFlag   <= highDefModeFlag;
                    hdFrequencyChoice <= hdFrequencyChoice;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parallel word: full 20 bits in HIGH_DEF_MODE_FLAG word in the upper ten bits.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rxParallelWord <= '0;
            wordValid      <= 1'b0;
        end else begin
            wordValid <= wordTick; // [RQ8]
            if (highDefModeFlag) begin
                rxParallelWord <= rxWordIn; // [RQ8] [RQ9]
            end else if (wordRateStrobe) begin
                rxParallelWord <= {sdWordIn, {SD_WIDTH{1'b0}}}; // [RQ19]
            end
        end
    end

    // Lock indicator.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            locked <= 1'b0;
        end else begin
            locked <= (state_q == LOCKED);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checksum on the upper channel of the word.
    mrsrx_crc_check u_crc (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .wordValid (wordTick && state_q == LOCKED),
        .wordIn    (highDefModeFlag ? rxWordIn[WORD_WIDTH-1:SD_WIDTH] : sdWordIn),
        .lineEnd   (lineEnd),
        .expected  (expectedCrc),
        .crcError  (crcRaw)
    );

    // Indicators stretch each error so it stays visible; a new error restarts it.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            hold_q      <= '0;
            crcErrorLed <= 1'b0;
            edhErrorLed <= 1'b0;
        end else begin
            if (crcRaw || edhErrorFlag) begin
                hold_q <= 13'(HOLD);
            end else if (hold_q != 13'h0000) begin
                hold_q <= hold_q - 13'h0001;
            end
            crcErrorLed <= crcRaw | (crcErrorLed && hold_q != 13'h0000); // [RQ16]
            edhErrorLed <= edhErrorFlag | (edhErrorLed && hold_q != 13'h0000); // [RQ16]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    property p_sd_mode;
        @(posedge clock) disable iff (sys_rst)
        state_q == HUNT_SD |=> !highDefModeFlag;
    endproperty
    a_sd_mode: assert property (p_sd_mode) else $error("SD hunt not in SD mode"); // [RQ18]

    property p_mil_rate;
        @(posedge clock) disable iff (sys_rst)
        state_q == HUNT_HD_MIL |=> hdFrequencyChoice && highDefModeFlag;
    endproperty
    a_mil_rate: assert property (p_mil_rate) else $error("Rate choice wrong"); // [RQ14]

    property p_nom_rate;
        @(posedge clock) disable iff (sys_rst)
        state_q == HUNT_HD_NOM |=> !hdFrequencyChoice;
    endproperty
    a_nom_rate: assert property (p_nom_rate) else $error("Nominal rate wrong"); // [RQ14]

    property p_stable_locked;
        @(posedge clock) disable iff (sys_rst)
        $past(state_q) == LOCKED && state_q == LOCKED |-> $stable(highDefModeFlag);
    endproperty
    a_stable_locked: assert property (p_stable_locked) else $error("Mode moved"); // [RQ20]

    property p_sd_hold;
        @(posedge clock) disable iff (sys_rst)
        !highDefModeFlag && !wordRateStrobe |=> $stable(rxParallelWord);
    endproperty
    a_sd_hold: assert property (p_sd_hold) else $error("SD word moved"); // [RQ19]

    property p_valid;
        @(posedge clock) disable iff (sys_rst)
        highDefModeFlag |=> wordValid;
    endproperty
    a_valid: assert property (p_valid) else $error("HD word not valid"); // [RQ8]

    property p_crc_led;
        @(posedge clock) disable iff (sys_rst)
        crcRaw |=> crcErrorLed;
    endproperty
    a_crc_led: assert property (p_crc_led) else $error("CRC led missing"); // [RQ16]

    property p_edh_led;
        @(posedge clock) disable iff (sys_rst)
        edhErrorFlag |=> edhErrorLed [*2];
    endproperty
    a_edh_led: assert property (p_edh_led) else $error("EDH led short"); // [RQ16]

    property p_lock;
        @(posedge clock) disable iff (sys_rst)
        state_q != LOCKED && wordTick && trsSeen |=> ##1 locked;
    endproperty
    a_lock: assert property (p_lock) else $error("Lock late"); // [RQ15]

    c_lock_hd: cover property (@(posedge clock) locked && highDefModeFlag);
    c_lock_sd: cover property (@(posedge clock) locked && !highDefModeFlag);
    c_lock_mil: cover property (@(posedge clock) locked && hdFrequencyChoice);
    c_crc: cover property (@(posedge clock) crcErrorLed);
endmodule

// >>> rtl/mrsrx_crc_check.sv
// Line checksum accumulator and comparator for one 10-bit video channel.
`timescale 1ns/1ps
module mrsrx_crc_check
    import mrsrx_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    // Word stream.
    input  wire logic                 wordValid,
    input  wire logic [SD_WIDTH-1:0]  wordIn,
    input  wire logic                 lineEnd,
    input  wire logic [CRC_WIDTH-1:0] expected,
    // Result.
    output logic                      crcError
);
    logic [CRC_WIDTH-1:0] crc_q;

    // One step of the x^18+x^5+x^4+1 checksum over a 10-bit word.
    function automatic logic [CRC_WIDTH-1:0] crcStep(input logic [CRC_WIDTH-1:0] c,
                                                     input logic [SD_WIDTH-1:0] w);
        logic [CRC_WIDTH-1:0] r;
        logic                 fb;
        r = c;
        for (int i = 0; i < SD_WIDTH; i++) begin
            fb = r[0] ^ w[i];
            r  = {fb, r[CRC_WIDTH-1:1]} ^ (fb ? 18'h00018 : 18'h00000);
        end
        return r;
    endfunction

    // Accumulate words and restart at each line end.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            crc_q <= '0;
        end else if (wordValid && lineEnd) begin
            crc_q <= '0;
        end else if (wordValid) begin
            crc_q <= crcStep(crc_q, wordIn);
        end
    end

    // Compare at line end and hold the verdict until the next line.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            crcError <= 1'b0;
        end else if (wordValid && lineEnd) begin
            crcError <= (crc_q != expected); // [RQ16]
        end
    end
endmodule
